//--- cpu_irq_pkg.sv
// constants and types shared by the interrupt response logic
package cpu_irq_pkg;

  localparam int TIMER_W = 4;

  // restart targets in page 0
  localparam logic [15:0] NMI_RESTART_ADDR = 16'h0066;
  localparam logic [15:0] MODE1_RESTART_ADDR = 16'h0038;

  // response modes
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;

  // values after reset
  localparam logic [1:0] MODE_RESET = MODE_0;
  localparam logic [7:0] VECTOR_BASE_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // cycle counts of each phase
  localparam logic [TIMER_W-1:0] M1_CYCLES = 4'h4;
  localparam logic [TIMER_W-1:0] ACK_WAIT_CYCLES = 4'h2;
  localparam logic [TIMER_W-1:0] MODE0_ACK_CYCLES = 4'(M1_CYCLES + ACK_WAIT_CYCLES);
  localparam logic [TIMER_W-1:0] VECTOR_ACK_CYCLES = 4'h7;
  localparam logic [TIMER_W-1:0] NMI_FETCH_CYCLES = 4'h5;
  localparam logic [TIMER_W-1:0] PUSH_BYTE_CYCLES = 4'h3;
  localparam logic [TIMER_W-1:0] TABLE_BYTE_CYCLES = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACK = 3'h1,
    ST_PUSH_HI = 3'h3,
    ST_PUSH_LO = 3'h2,
    ST_TABLE_LO = 3'h6,
    ST_TABLE_HI = 3'h7,
    ST_NMI_FETCH = 3'h5
  } resp_state_type;

endpackage

//--- phase_timer_if.sv
// handshake between the response sequencer and its phase timer
`timescale 1ns/1ns
interface phase_timer_if;
  logic start;
  logic [cpu_irq_pkg::TIMER_W-1:0] length;
  logic done;
  modport ctrl (output start, output length, input done);
  modport tmr (input start, input length, output done);
endinterface

//--- phase_timer.sv
// down counter that times one bus phase of the response sequence
`timescale 1ns/1ns
module phase_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // phase control
  phase_timer_if.tmr tif
);

  logic [cpu_irq_pkg::TIMER_W-1:0] count_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (tif.start) begin
      count_q <= tif.length;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // last cycle of a phase; a restart in that cycle chains phases back to back
  assign tif.done = (count_q == cpu_irq_pkg::TIMER_W'(1));

endmodule

//--- cpu_interrupt_response.sv
// interrupt acceptance, enable flags and response sequencing of the cpu
`timescale 1ns/1ns
module cpu_interrupt_response (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // interrupt requests
  input wire logic irqReq,
  input wire logic nmiReq,
  // instruction stream from the core, pulses in the completing cycle
  input wire logic instrDone,
  input wire logic enableIrqOp,
  input wire logic disableIrqOp,
  input wire logic returnFromNmiOp,
  input wire logic loadAccFromVectorBaseOp,
  input wire logic loadAccFromRefreshOp,
  input wire logic setModeOp,
  input wire logic [1:0] modeSel,
  input wire logic loadVectorBaseOp,
  input wire logic [7:0] vectorBaseIn,
  // core state used by the restart
  input wire logic [15:0] pcIn,
  input wire logic [15:0] spIn,
  // data bus
  input wire logic [7:0] dataIn,
  // core control
  output logic busy,
  output logic nmiFetch,
  output logic ackCycle,
  output logic injectValid,
  output logic [7:0] injectOp,
  output logic pcLoad,
  output logic [15:0] pcTarget,
  output logic spLoad,
  output logic [15:0] spValue,
  // memory cycles
  output logic memRd,
  output logic memWr,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  // flags and status
  output logic parityLoad,
  output logic parityValue,
  output logic irqEnableFlag,
  output logic irqEnableShadow,
  output logic [1:0] irqMode,
  output logic [7:0] vectorBase
);

  phase_timer_if tif ();

  phase_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .tif(tif)
  );

  cpu_irq_pkg::resp_state_type state_q;
  cpu_irq_pkg::resp_state_type state_d;
  logic irqEnableFlag_q;
  logic irqEnableShadow_q;
  logic [1:0] irqMode_q;
  logic [7:0] vectorBase_q;
  logic nmiPending_q;
  logic nmiReqPrev_q;
  logic fromNmi_q;
  logic [15:0] retAddr_q;
  logic [15:0] target_q;
  logic [7:0] vecLo_q;
  logic parityLoad_q;
  logic parityValue_q;
  logic injectValid_q;
  logic [7:0] injectOp_q;
  logic pcLoad_q;
  logic spLoad_q;
  logic [15:0] spValue_q;
  logic memRd_q;
  logic memWr_q;
  logic [15:0] memAddr_q;
  logic [7:0] memWrData_q;
  logic acceptNmi;
  logic acceptIrq;
  wire logic nmiRise = nmiReq && !nmiReqPrev_q;
  wire logic phaseDone = tif.done;
  // pointer is always even whatever the peripheral drove
  wire logic [15:0] tablePtr = {vectorBase_q, vecLo_q[7:1], 1'b0};

  // acceptance only at a boundary while idle; nonmaskable first
  always_comb begin
    acceptNmi = instrDone && (state_q == cpu_irq_pkg::ST_IDLE) && nmiPending_q;
    // the boundary of the enable instruction itself is skipped
    acceptIrq = instrDone && (state_q == cpu_irq_pkg::ST_IDLE) && !nmiPending_q
                && irqReq && irqEnableFlag_q && !enableIrqOp;
  end

  // nonmaskable request is edge sensitive and latched until served
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmiReqPrev_q <= 1'b0;
      nmiPending_q <= 1'b0;
    end else begin
      nmiReqPrev_q <= nmiReq;
      // a new edge in the accepting cycle wins over the clear
      if (nmiRise) begin
        nmiPending_q <= 1'b1;
      end else if (acceptNmi) begin
        nmiPending_q <= 1'b0;
      end
    end
  end

  // enable flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqEnableFlag_q <= cpu_irq_pkg::FLAG_RESET;
      irqEnableShadow_q <= cpu_irq_pkg::FLAG_RESET;
    end else if (acceptNmi) begin
      irqEnableFlag_q <= 1'b0;
      irqEnableShadow_q <= !disableIrqOp && (enableIrqOp || irqEnableShadow_q);
    end else if (acceptIrq) begin
      irqEnableFlag_q <= 1'b0;
      irqEnableShadow_q <= 1'b0;
    end else if (disableIrqOp) begin
      irqEnableFlag_q <= 1'b0;
      irqEnableShadow_q <= 1'b0;
    end else if (enableIrqOp) begin
      irqEnableFlag_q <= 1'b1;
      irqEnableShadow_q <= 1'b1;
    end else if (returnFromNmiOp) begin
      irqEnableFlag_q <= irqEnableShadow_q;
    end
  end

  // parity flag copy for the two accumulator loads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      parityLoad_q <= 1'b0;
      parityValue_q <= 1'b0;
    end else begin
      parityLoad_q <= loadAccFromVectorBaseOp || loadAccFromRefreshOp;
      parityValue_q <= (loadAccFromVectorBaseOp || loadAccFromRefreshOp) ? irqEnableShadow_q
                       : parityValue_q;
    end
  end

  // response mode and vector base
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqMode_q <= cpu_irq_pkg::MODE_RESET;
      vectorBase_q <= cpu_irq_pkg::VECTOR_BASE_RESET;
    end else begin
      // the unused fourth code falls back to mode 0
      if (setModeOp) begin
        irqMode_q <= (modeSel == 2'h3) ? cpu_irq_pkg::MODE_0 : modeSel;
      end
      vectorBase_q <= loadVectorBaseOp ? vectorBaseIn : vectorBase_q;
    end
  end

  // sequencer next state and phase timer start
  always_comb begin
    state_d = state_q;
    tif.start = 1'b0;
    tif.length = '0;
    unique case (state_q)
      cpu_irq_pkg::ST_IDLE: begin
        if (acceptNmi) begin
          state_d = cpu_irq_pkg::ST_NMI_FETCH;
          tif.start = 1'b1;
          tif.length = cpu_irq_pkg::NMI_FETCH_CYCLES;
        end else if (acceptIrq) begin
          state_d = cpu_irq_pkg::ST_ACK;
          tif.start = 1'b1;
          tif.length = (irqMode_q == cpu_irq_pkg::MODE_0) ? cpu_irq_pkg::MODE0_ACK_CYCLES
                       : cpu_irq_pkg::VECTOR_ACK_CYCLES;
        end
      end
      cpu_irq_pkg::ST_NMI_FETCH: begin
        if (phaseDone) begin
          state_d = cpu_irq_pkg::ST_PUSH_HI;
          tif.start = 1'b1;
          tif.length = cpu_irq_pkg::PUSH_BYTE_CYCLES;
        end
      end
      cpu_irq_pkg::ST_ACK: begin
        if (phaseDone) begin
          if (irqMode_q == cpu_irq_pkg::MODE_0) begin
            state_d = cpu_irq_pkg::ST_IDLE;
          end else begin
            state_d = cpu_irq_pkg::ST_PUSH_HI;
            tif.start = 1'b1;
            tif.length = cpu_irq_pkg::PUSH_BYTE_CYCLES;
          end
        end
      end
      cpu_irq_pkg::ST_PUSH_HI: begin
        if (phaseDone) begin
          state_d = cpu_irq_pkg::ST_PUSH_LO;
          tif.start = 1'b1;
          tif.length = cpu_irq_pkg::PUSH_BYTE_CYCLES;
        end
      end
      cpu_irq_pkg::ST_PUSH_LO: begin
        if (phaseDone) begin
          if (!fromNmi_q && irqMode_q == cpu_irq_pkg::MODE_2) begin
            state_d = cpu_irq_pkg::ST_TABLE_LO;
            tif.start = 1'b1;
            tif.length = cpu_irq_pkg::TABLE_BYTE_CYCLES;
          end else begin
            state_d = cpu_irq_pkg::ST_IDLE;
          end
        end
      end
      cpu_irq_pkg::ST_TABLE_LO: begin
        if (phaseDone) begin
          state_d = cpu_irq_pkg::ST_TABLE_HI;
          tif.start = 1'b1;
          tif.length = cpu_irq_pkg::TABLE_BYTE_CYCLES;
        end
      end
      cpu_irq_pkg::ST_TABLE_HI: begin
        if (phaseDone) begin
          state_d = cpu_irq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = cpu_irq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= cpu_irq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // per-response context: cause, return address, target
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fromNmi_q <= 1'b0;
      retAddr_q <= '0;
      target_q <= '0;
      vecLo_q <= '0;
    end else begin
      if (acceptNmi || acceptIrq) begin
        fromNmi_q <= acceptNmi;
        retAddr_q <= pcIn;
        target_q <= acceptNmi ? cpu_irq_pkg::NMI_RESTART_ADDR
                    : cpu_irq_pkg::MODE1_RESTART_ADDR;
      end
      vecLo_q <= (state_q == cpu_irq_pkg::ST_ACK && phaseDone) ? dataIn : vecLo_q;
      // table entry arrives low byte first
      if (state_q == cpu_irq_pkg::ST_TABLE_LO && phaseDone) begin
        target_q[7:0] <= dataIn;
      end
      if (state_q == cpu_irq_pkg::ST_TABLE_HI && phaseDone) begin
        target_q[15:8] <= dataIn;
      end
    end
  end

  // mode 0 hand-over of the peripheral's opcode to the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      injectValid_q <= 1'b0;
      injectOp_q <= '0;
    end else begin
      injectValid_q <= (state_q == cpu_irq_pkg::ST_ACK) && phaseDone
                       && (irqMode_q == cpu_irq_pkg::MODE_0);
      injectOp_q <= (state_q == cpu_irq_pkg::ST_ACK && phaseDone) ? dataIn : injectOp_q;
    end
  end

  // stack pushes and table reads; memory answers within each 3-clock phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memRd_q <= 1'b0;
      memWr_q <= 1'b0;
      memAddr_q <= '0;
      memWrData_q <= '0;
    end else begin
      memWr_q <= (state_d == cpu_irq_pkg::ST_PUSH_HI) || (state_d == cpu_irq_pkg::ST_PUSH_LO);
      memRd_q <= (state_d == cpu_irq_pkg::ST_TABLE_LO) || (state_d == cpu_irq_pkg::ST_TABLE_HI);
      unique case (state_d)
        cpu_irq_pkg::ST_PUSH_HI: begin
          memAddr_q <= spIn - 16'h0001;
          memWrData_q <= retAddr_q[15:8];
        end
        cpu_irq_pkg::ST_PUSH_LO: begin
          memAddr_q <= spIn - 16'h0002;
          memWrData_q <= retAddr_q[7:0];
        end
        cpu_irq_pkg::ST_TABLE_LO: begin
          memAddr_q <= tablePtr;
        end
        cpu_irq_pkg::ST_TABLE_HI: begin
          memAddr_q <= tablePtr + 16'h0001;
        end
        default: begin
          memAddr_q <= memAddr_q;
        end
      endcase
    end
  end

  // jump at the end of the sequence, stack pointer lowered by two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcLoad_q <= 1'b0;
      spLoad_q <= 1'b0;
      spValue_q <= '0;
    end else begin
      pcLoad_q <= (state_q != cpu_irq_pkg::ST_IDLE) && (state_d == cpu_irq_pkg::ST_IDLE)
                  && !(state_q == cpu_irq_pkg::ST_ACK);
      spLoad_q <= (state_q == cpu_irq_pkg::ST_PUSH_LO) && phaseDone;
      if ((state_q == cpu_irq_pkg::ST_PUSH_LO) && phaseDone) begin
        spValue_q <= spIn - 16'h0002;
      end
    end
  end

  assign pcTarget = target_q;
  assign busy = (state_q != cpu_irq_pkg::ST_IDLE);
  assign nmiFetch = (state_q == cpu_irq_pkg::ST_NMI_FETCH);
  assign ackCycle = (state_q == cpu_irq_pkg::ST_ACK);
  assign injectValid = injectValid_q;
  assign injectOp = injectOp_q;
  assign pcLoad = pcLoad_q;
  assign spLoad = spLoad_q;
  assign spValue = spValue_q;
  assign memRd = memRd_q;
  assign memWr = memWr_q;
  assign memAddr = memAddr_q;
  assign memWrData = memWrData_q;
  assign parityLoad = parityLoad_q;
  assign parityValue = parityValue_q;
  assign irqEnableFlag = irqEnableFlag_q;
  assign irqEnableShadow = irqEnableShadow_q;
  assign irqMode = irqMode_q;
  assign vectorBase = vectorBase_q;

endmodule

//--- cpu_interrupt_response_assertions.sv
// port-level property checker for the interrupt response block
`timescale 1ns/1ns
module cpu_interrupt_response_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // requests and instruction stream
  input wire logic nmiReq,
  input wire logic instrDone,
  input wire logic enableIrqOp,
  input wire logic disableIrqOp,
  input wire logic returnFromNmiOp,
  input wire logic loadAccFromVectorBaseOp,
  input wire logic loadAccFromRefreshOp,
  // sequencer outputs
  input wire logic busy,
  input wire logic nmiFetch,
  input wire logic ackCycle,
  input wire logic pcLoad,
  input wire logic spLoad,
  input wire logic [15:0] pcTarget,
  input wire logic memRd,
  input wire logic memWr,
  // flags and status
  input wire logic parityLoad,
  input wire logic parityValue,
  input wire logic irqEnableFlag,
  input wire logic irqEnableShadow,
  input wire logic [1:0] irqMode,
  input wire logic [7:0] vectorBase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_state: assert property ($rose(rstn) |-> !irqEnableFlag && !irqEnableShadow
    && irqMode == cpu_irq_pkg::MODE_0 && vectorBase == 8'h00) else $error("state after reset wrong");
  a_di_clears: assert property (instrDone && disableIrqOp
    |=> !irqEnableFlag && !irqEnableShadow) else $error("disable left a flag set");
  a_ei_sets_both: assert property (instrDone && enableIrqOp && !disableIrqOp && !busy && !nmiReq
    |=> irqEnableShadow && (nmiFetch || irqEnableFlag && !busy)) else $error("enable boundary wrong");
  a_mask_blocks: assert property (!busy && !irqEnableFlag |=> !ackCycle)
    else $error("maskable taken while disabled");
  a_accept_clears: assert property ($rose(ackCycle) |-> !irqEnableFlag && !irqEnableShadow)
    else $error("flags kept on maskable accept");
  a_nmi_shadow: assert property ($rose(nmiFetch) && !$past(enableIrqOp)
    && !$past(disableIrqOp) |-> !irqEnableFlag && irqEnableShadow == $past(irqEnableShadow))
    else $error("nmi flag update wrong");
  a_nmi_unmasked: assert property ($rose(nmiReq) && !busy ##1 instrDone && !busy |=> nmiFetch)
    else $error("nmi not taken");
  a_nmi_restart: assert property ($rose(nmiFetch) |-> nmiFetch[*5] ##1 memWr[*6]
    ##[1:2] (pcLoad && pcTarget == cpu_irq_pkg::NMI_RESTART_ADDR)) else $error("nmi restart wrong");
  a_mode1_restart: assert property ($rose(ackCycle) && irqMode == cpu_irq_pkg::MODE_1
    |-> ackCycle[*7] ##1 memWr[*6] ##[1:2] (pcLoad && pcTarget == cpu_irq_pkg::MODE1_RESTART_ADDR))
    else $error("mode 1 restart wrong");
  a_mode2_timing: assert property ($rose(ackCycle) && irqMode == cpu_irq_pkg::MODE_2
    |-> ackCycle[*7] ##1 memWr[*6] ##1 memRd[*6] ##1 pcLoad) else $error("mode 2 timing wrong");
  a_mode0_waits: assert property ($rose(ackCycle) && irqMode == cpu_irq_pkg::MODE_0
    |-> ackCycle[*6] ##1 !ackCycle) else $error("mode 0 acknowledge length wrong");
  a_return_from_nmi_op_restore: assert property (instrDone && returnFromNmiOp && !busy && !disableIrqOp
    && !enableIrqOp |=> busy || irqEnableFlag == $past(irqEnableShadow))
    else $error("return restore wrong");
  a_parity_copy: assert property (instrDone && (loadAccFromVectorBaseOp || loadAccFromRefreshOp)
    |=> parityLoad && parityValue == $past(irqEnableShadow)) else $error("parity copy wrong");
  a_sp_with_push: assert property ($fell(memWr) |-> spLoad)
    else $error("stack pointer not lowered after pushes");
endmodule

bind cpu_interrupt_response cpu_interrupt_response_assertions cpu_interrupt_response_assertions_inst (.*);

//--- irq_peripheral_model.sv
// interrupting peripheral plus stack and vector table memory
`timescale 1ns/1ns
module irq_peripheral_model (
  // clock
  input wire logic clk,
  // cpu bus
  input wire logic ackCycle,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  // byte offered during acknowledge
  input wire logic [7:0] respByte,
  // data bus and stack bytes in write order
  output logic [7:0] dataIn,
  output logic [15:0] pushed,
  output logic [15:0] pushAddr
);
  logic wrSeen = 1'b0;
  logic [15:0] lastAddr = 16'h0000;
  initial dataIn = 8'h00;
  initial pushed = 16'h0000;
  initial pushAddr = 16'h0000;
  always @(posedge clk) begin
    wrSeen <= memWr;
    lastAddr <= memAddr;
    if (memWr && (!wrSeen || memAddr != lastAddr)) pushed <= {pushed[7:0], memWrData};
    if (memWr) pushAddr <= memAddr;
    if (ackCycle) dataIn <= respByte;
    else if (memRd) dataIn <= memAddr[15:8] ^ memAddr[7:0] ^ 8'h5A;
    // released bus toggles so a stale byte is never mistaken for data
    else dataIn <= ~dataIn;
  end
endmodule

//--- cpu_interrupt_response_tb.sv
// self-checking bench for the interrupt response block
`timescale 1ns/1ns
module cpu_interrupt_response_tb;
  logic clk = 1'b0, rstn = 1'b0, irqReq = 1'b0, nmiReq = 1'b0, instrDone = 1'b0;
  logic enableIrqOp = 1'b0, disableIrqOp = 1'b0, returnFromNmiOp = 1'b0, setModeOp = 1'b0;
  logic loadAccFromVectorBaseOp = 1'b0, loadAccFromRefreshOp = 1'b0, loadVectorBaseOp = 1'b0;
  logic [1:0] modeSel = 2'h0, irqMode;
  logic [7:0] vectorBaseIn = 8'h00, respByte = 8'h00, dataIn, injectOp, memWrData, vectorBase, vec;
  logic [15:0] pcIn = 16'h0000, spIn = 16'h0000, pcTarget, spValue, memAddr, pushed, pc, pushAddr;
  logic busy, nmiFetch, ackCycle, injectValid, pcLoad, spLoad, memRd, memWr;
  logic parityLoad, parityValue, irqEnableFlag, irqEnableShadow;
  int failures = 0, samples_checked = 0, cycles = 0, seed = 4221, n, acks;
  cpu_interrupt_response cpu_interrupt_response_inst (.*);
  irq_peripheral_model irq_peripheral_model_inst (.*);
  always #20 clk = ~clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // whole run needs well under a thousand cycles
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction boundary carrying the given op pulses
  task automatic step(input logic [6:0] ops);
    @(negedge clk);
    {loadVectorBaseOp, setModeOp, loadAccFromRefreshOp, loadAccFromVectorBaseOp,
      returnFromNmiOp, disableIrqOp, enableIrqOp} = ops;
    instrDone = 1'b1;
    pcIn = 16'($random(seed));
    spIn = 16'($random(seed));
    @(negedge clk);
    {loadVectorBaseOp, setModeOp, loadAccFromRefreshOp, loadAccFromVectorBaseOp,
      returnFromNmiOp, disableIrqOp, enableIrqOp} = 7'h00;
    instrDone = 1'b0;
  endtask
  task automatic serve();
    n = 1;
    acks = 0;
    while (!(pcLoad === 1'b1 || injectValid === 1'b1) && n < 40) begin
      acks += int'(ackCycle === 1'b1);
      @(negedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 80) begin
      @(negedge clk);
      n += 100;
    end
  endtask
  function automatic logic [15:0] entry(input logic [7:0] b, input logic [7:0] v);
    return {b ^ (v | 8'h01) ^ 8'h5A, b ^ v ^ 8'h5A};
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    @(negedge clk);
    check("flags", 16'h0000, {irqEnableFlag, irqEnableShadow});
    check("mode", 16'(cpu_irq_pkg::MODE_0), irqMode);
    check("base", 16'h0000, vectorBase);
    irqReq = 1'b1;
    step(7'h00);
    check("masked", 16'h0000, busy);
    for (int m = 0; m < 4; m++) begin
      modeSel = 2'(m);
      step(7'h20);
      check("mode sel", (m == 3) ? 16'h0000 : 16'(m), irqMode);
    end
    for (int k = 0; k < 5; k++) begin
      irqReq = 1'b0;
      modeSel = (k > 1) ? 2'h2 : 2'(k);
      vectorBaseIn = 8'($random(seed));
      vec = 8'($random(seed)) & 8'hFE;
      respByte = (k == 0) ? 8'($random(seed)) : vec;
      step(7'h60);
      check("base load", vectorBaseIn, vectorBase);
      irqReq = 1'b1;
      step(7'h01);
      check("ei flags", 16'h0003, {irqEnableFlag, irqEnableShadow});
      check("ei delay", 16'h0000, busy);
      step(7'h00);
      pc = pcIn;
      irqReq = 1'b0;
      check("accept flags", 16'h0000, {irqEnableFlag, irqEnableShadow});
      serve();
      check("ack len", (k == 0) ? 16'd6 : 16'd7, 16'(acks));
      if (k == 0) check("mode 0 op", respByte, injectOp);
      if (k == 1) check("mode 1 target", 16'h0038, pcTarget);
      if (k > 1) check("mode 2 len", 16'd19, 16'(n - 1));
      if (k > 1) check("mode 2 target", entry(vectorBaseIn, vec), pcTarget);
      if (k > 0) check("pushed pc", pc, pushed);
      if (k > 0) check("sp lowered", spIn - 16'h0002, spValue);
      if (k > 0) check("push addr", spIn - 16'h0002, pushAddr);
    end
    step(7'h01);
    @(negedge clk) nmiReq = 1'b1;
    step(7'h00);
    pc = pcIn;
    nmiReq = 1'b0;
    check("nmi flags", 16'h0001, {irqEnableFlag, irqEnableShadow});
    serve();
    check("nmi target", 16'h0066, pcTarget);
    check("nmi pushed", pc, pushed);
    check("nmi sp", spIn - 16'h0002, spValue);
    step(7'h08);
    check("parity i", 16'h0001, parityValue);
    step(7'h04);
    check("return_from_nmi_op flags", 16'h0003, {irqEnableFlag, irqEnableShadow});
    step(7'h02);
    check("di flags", 16'h0000, {irqEnableFlag, irqEnableShadow});
    @(negedge clk) nmiReq = 1'b1;
    step(7'h00);
    nmiReq = 1'b0;
    check("nmi unmasked", 16'h0001, nmiFetch);
    serve();
    step(7'h10);
    check("parity r", 16'h0000, parityValue);
    wrap_up();
  end
endmodule
